// ---- core/port_select_pkg.sv ----
// Constants shared by the serial host port select logic.
// Assumes a 250 MHz system clock and a host-driven serial clock.
package port_select_pkg;

    localparam int         SYNC_STAGES   = 3;       // Flops on every pin input
    localparam int         PIN_COUNT     = 4;       // Strap, clock, data, select pins
    localparam int         PIN_STRAP     = 0;       // Bit positions in pin bundle
    localparam int         PIN_CLK       = 1;
    localparam int         PIN_DATA      = 2;
    localparam int         PIN_SEL       = 3;
    localparam int         BYTE_BITS     = 8;       // Serial byte width
    localparam int         BIT_CNT_W     = 3;
    localparam int         STATUS_W      = 8;       // Status bits that may interrupt
    localparam logic [2:0] BIT_CNT_LAST  = 3'h7;    // Count of the last bit of a byte
    localparam logic [2:0] BIT_CNT_RST   = 3'h0;
    localparam logic [7:0] BYTE_RST      = 8'h00;
    localparam logic [7:0] STATUS_RST    = 8'h00;
    localparam logic       STRAP_RST     = 1'b1;    // Pulled-high strap selects I2C
    localparam logic       PIN_IDLE_RST  = 1'b1;    // Released lines read high
    localparam logic [3:0] PIN_BUNDLE_RST = 4'hf;
    localparam logic       OE_RELEASED   = 1'b1;    // Enable high means not driving
    localparam logic       DRIVE_LOW     = 1'b0;    // Open-drain only ever drives 0

endpackage

// ---- core/pin_sync3.sv ----
// Three-flop synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk; output changes once stages 2 and 3 agree.
`timescale 1ns/1ps
module pin_sync3
    import port_select_pkg::*;
#(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    // Per bit, follow stage 3 only when stages 2 and 3 match
    always_comb begin
        for (int i = 0; i < W; i++) begin
            nxt_q[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : q_ff[i];
        end
    end

    // Stage 1 feeds stage 2 only
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            q_ff  <= RST_VAL;
        end else if (ce) begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff  <= nxt_q;
        end
    end

    assign q = q_ff;

endmodule // pin_sync3

// ---- core/serial_host_port_select.sv ----
// Pin front end of the configuration port: SPI or I2C role select, open-drain irq.
// Assumes protocol engines sit on sys_clk; the host clocks the serial pins.
`timescale 1ns/1ps
/////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Strap low: clock pin is SPI clock; strap high: bidirectional I2C clock.
// - Strap low: data pin is SPI input; strap high: bidirectional I2C data.
// - Serial read data driven on its output pin only in SPI mode.
// - SPI: select pin is active-low chip select; respond only while low.
// - I2C: select pin sampled as address bit 0, never a chip select.
// - Interrupt line asserted low when enabled status changes, in either mode.
// - Interrupt line open-drain: pull low or release; external pull-up.
// - Strap high or floating enables I2C; low enables SPI.
module serial_host_port_select
    import port_select_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic                ce,
    input  wire logic                link_clk,
    input  wire logic                bus_select,
    input  wire logic                host_clk_pin_in,
    output logic                     host_clk_pin_out,
    output logic                     host_clk_pin_oe,
    input  wire logic                host_data_pin_in,
    output logic                     host_data_pin_out,
    output logic                     host_data_pin_oe,
    input  wire logic                select_or_addr_pin,
    output logic                     spi_data_out,
    output logic                     spi_data_out_oe,
    output logic                     irq_n_out,
    output logic                     irq_n_oe,
    input  wire logic                spi_read_bit,
    input  wire logic                i2c_clk_hold_low,
    input  wire logic                i2c_data_drive_low,
    input  wire logic [STATUS_W-1:0] status_in,
    input  wire logic [STATUS_W-1:0] status_enable,
    input  wire logic                status_read,
    output logic                     i2c_mode,
    output logic                     spi_selected,
    output logic                     addr_select_bit0,
    output logic                     i2c_clk_level,
    output logic                     i2c_data_level,
    output logic [BYTE_BITS-1:0]     spi_rx_byte,
    output logic                     spi_rx_valid
);

    /////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [PIN_COUNT-1:0] pins_sync;
    logic                 rx_tgl_sync;
    logic                 rx_tgl_link_ff;

    pin_sync3 #(
        .W       (PIN_COUNT),
        .RST_VAL (PIN_BUNDLE_RST)
    ) u_pin_sync (
        .clk (sys_clk),
        .rst (rst),
        .ce  (ce),
        .din ({select_or_addr_pin, host_data_pin_in, host_clk_pin_in, bus_select}),
        .q   (pins_sync)
    );

    pin_sync3 #(
        .W       (1),
        .RST_VAL (1'b0)
    ) u_tgl_sync (
        .clk (sys_clk),
        .rst (rst),
        .ce  (ce),
        .din (rx_tgl_link_ff),
        .q   (rx_tgl_sync)
    );

    /////////////////////////////////////////////////////////////////////////////
    // Mode and pin roles (sys_clk)

    logic                 i2c_mode_ff;
    logic                 spi_sel_ff;
    logic                 addr_bit0_ff;
    logic                 clk_level_ff;
    logic                 data_level_ff;
    logic                 clk_oe_ff;
    logic                 data_oe_ff;
    logic                 so_ff;
    logic                 so_oe_ff;
    logic                 pin_low_ff;
    logic                 nxt_i2c_mode;
    logic                 nxt_spi_sel;
    logic                 nxt_addr_bit0;
    logic                 nxt_clk_level;
    logic                 nxt_data_level;
    logic                 nxt_clk_oe;
    logic                 nxt_data_oe;
    logic                 nxt_so;
    logic                 nxt_so_oe;

    // Role of each shared pin from the filtered strap
    always_comb begin
        nxt_i2c_mode   = pins_sync[PIN_STRAP];
        nxt_spi_sel    = ~i2c_mode_ff & ~pins_sync[PIN_SEL];
        nxt_addr_bit0  = i2c_mode_ff ? pins_sync[PIN_SEL] : addr_bit0_ff;
        nxt_clk_level  = pins_sync[PIN_CLK];
        nxt_data_level = pins_sync[PIN_DATA];
        nxt_clk_oe     = ~(i2c_mode_ff & i2c_clk_hold_low);
        nxt_data_oe    = ~(i2c_mode_ff & i2c_data_drive_low);
        nxt_so         = spi_sel_ff ? spi_read_bit : so_ff;
        nxt_so_oe      = ~(~i2c_mode_ff & spi_sel_ff);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            i2c_mode_ff   <= STRAP_RST;
            spi_sel_ff    <= 1'b0;
            addr_bit0_ff  <= 1'b0;
            clk_level_ff  <= PIN_IDLE_RST;
            data_level_ff <= PIN_IDLE_RST;
            clk_oe_ff     <= OE_RELEASED;
            data_oe_ff    <= OE_RELEASED;
            so_ff         <= 1'b0;
            so_oe_ff      <= OE_RELEASED;
            pin_low_ff    <= DRIVE_LOW;
        end else if (ce) begin
            i2c_mode_ff   <= nxt_i2c_mode;
            spi_sel_ff    <= nxt_spi_sel;
            addr_bit0_ff  <= nxt_addr_bit0;
            clk_level_ff  <= nxt_clk_level;
            data_level_ff <= nxt_data_level;
            clk_oe_ff     <= nxt_clk_oe;
            data_oe_ff    <= nxt_data_oe;
            so_ff         <= nxt_so;
            so_oe_ff      <= nxt_so_oe;
            pin_low_ff    <= DRIVE_LOW;
        end
    end

    /////////////////////////////////////////////////////////////////////////////
    // Interrupt: sticky change of enabled status

    logic [STATUS_W-1:0] status_last_ff;
    logic                irq_pend_ff;
    logic                irq_oe_ff;
    logic [STATUS_W-1:0] nxt_status_last;
    logic                nxt_irq_pend;
    logic                nxt_irq_oe;
    logic                status_changed;

    // Change on any enabled bit sets pending; set beats read clear
    always_comb begin
        status_changed  = |((status_in ^ status_last_ff) & status_enable);
        nxt_status_last = status_in;
        nxt_irq_pend    = status_changed | (irq_pend_ff & ~status_read);
        nxt_irq_oe      = ~irq_pend_ff;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_last_ff <= STATUS_RST;
            irq_pend_ff    <= 1'b0;
            irq_oe_ff      <= OE_RELEASED;
        end else if (ce) begin
            status_last_ff <= nxt_status_last;
            irq_pend_ff    <= nxt_irq_pend;
            irq_oe_ff      <= nxt_irq_oe;
        end
    end

    /////////////////////////////////////////////////////////////////////////////
    // Link domain: SPI input shifter on the host clock

    logic                 link_frame_rst;
    logic                 link_hard_rst_ff;
    logic [BYTE_BITS-1:0] shift_ff;
    logic [BIT_CNT_W-1:0] bit_cnt_ff;
    logic [BYTE_BITS-1:0] rx_byte_link_ff;
    logic [BYTE_BITS-1:0] nxt_shift;
    logic [BIT_CNT_W-1:0] nxt_bit_cnt;
    logic [BYTE_BITS-1:0] nxt_rx_byte_link;
    logic                 nxt_rx_tgl_link;

    // Shifter idles while deselected or in I2C mode
    assign link_frame_rst = select_or_addr_pin | i2c_mode_ff;

    always_comb begin
        nxt_shift        = {shift_ff[BYTE_BITS-2:0], host_data_pin_in};
        nxt_bit_cnt      = bit_cnt_ff + 3'h1;
        nxt_rx_byte_link = rx_byte_link_ff;
        nxt_rx_tgl_link  = rx_tgl_link_ff;
        if (bit_cnt_ff == BIT_CNT_LAST) begin
            nxt_rx_byte_link = nxt_shift;
            nxt_rx_tgl_link  = ~rx_tgl_link_ff;
        end
    end

    // Frame-scoped bit counter, cleared by chip select
    always_ff @(posedge link_clk or posedge link_frame_rst) begin
        if (link_frame_rst) begin
            shift_ff   <= BYTE_RST;
            bit_cnt_ff <= BIT_CNT_RST;
        end else begin
            shift_ff   <= nxt_shift;
            bit_cnt_ff <= nxt_bit_cnt;
        end
    end

    // Byte hold and toggle survive the frame end
    always_ff @(posedge link_clk or posedge link_hard_rst_ff) begin
        if (link_hard_rst_ff) begin
            rx_byte_link_ff <= BYTE_RST;
            rx_tgl_link_ff  <= 1'b0;
        end else begin
            rx_byte_link_ff <= nxt_rx_byte_link;
            rx_tgl_link_ff  <= nxt_rx_tgl_link;
        end
    end

    /////////////////////////////////////////////////////////////////////////////
    // Byte hand-off into sys_clk

    logic                 tgl_seen_ff;
    logic                 rx_valid_ff;
    logic [BYTE_BITS-1:0] rx_byte_ff;
    logic                 nxt_tgl_seen;
    logic                 nxt_rx_valid;
    logic [BYTE_BITS-1:0] nxt_rx_byte;

    // Held byte is stable once its toggle is seen
    always_comb begin
        nxt_tgl_seen = rx_tgl_sync;
        nxt_rx_valid = rx_tgl_sync ^ tgl_seen_ff;
        nxt_rx_byte  = nxt_rx_valid ? rx_byte_link_ff : rx_byte_ff;
    end

    always_ff @(posedge sys_clk) begin
        link_hard_rst_ff <= rst;
        if (rst) begin
            tgl_seen_ff <= 1'b0;
            rx_valid_ff <= 1'b0;
            rx_byte_ff  <= BYTE_RST;
        end else if (ce) begin
            tgl_seen_ff <= nxt_tgl_seen;
            rx_valid_ff <= nxt_rx_valid;
            rx_byte_ff  <= nxt_rx_byte;
        end
    end

    /////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign host_clk_pin_out  = pin_low_ff;
    assign host_clk_pin_oe   = clk_oe_ff;
    assign host_data_pin_out = pin_low_ff;
    assign host_data_pin_oe  = data_oe_ff;
    assign spi_data_out      = so_ff;
    assign spi_data_out_oe   = so_oe_ff;
    assign irq_n_out         = pin_low_ff;
    assign irq_n_oe          = irq_oe_ff;
    assign i2c_mode          = i2c_mode_ff;
    assign spi_selected      = spi_sel_ff;
    assign addr_select_bit0  = addr_bit0_ff;
    assign i2c_clk_level     = clk_level_ff;
    assign i2c_data_level    = data_level_ff;
    assign spi_rx_byte       = rx_byte_ff;
    assign spi_rx_valid      = rx_valid_ff;

endmodule // serial_host_port_select

// ---- tb/port_select_monitor.sv ----
// Checker for pin roles, open-drain drives and interrupt timing.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module port_select_monitor
    import port_select_pkg::*;
(
    input wire logic                sys_clk,
    input wire logic                rst,
    input wire logic                ce,
    input wire logic                bus_select,
    input wire logic                host_clk_pin_out,
    input wire logic                host_clk_pin_oe,
    input wire logic                host_data_pin_out,
    input wire logic                host_data_pin_oe,
    input wire logic                spi_data_out,
    input wire logic                spi_data_out_oe,
    input wire logic                irq_n_out,
    input wire logic                irq_n_oe,
    input wire logic                spi_read_bit,
    input wire logic                i2c_clk_hold_low,
    input wire logic                i2c_data_drive_low,
    input wire logic [STATUS_W-1:0] status_in,
    input wire logic [STATUS_W-1:0] status_enable,
    input wire logic                status_read,
    input wire logic                i2c_mode,
    input wire logic                spi_selected,
    input wire logic                addr_select_bit0,
    input wire logic                spi_rx_valid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || !ce);
    // Enabled status moved, and two cycles of I2C mode
    sequence s_change;
        ((status_in ^ $past(status_in)) & status_enable) != '0;
    endsequence
    sequence s_i2c2;
        i2c_mode ##1 i2c_mode;
    endsequence
    a_clk_role: assert property (!i2c_mode |=> host_clk_pin_oe)
        else $error("clock pin driven in spi mode");
    a_clk_hold: assert property (i2c_mode && i2c_clk_hold_low ##1 i2c_mode |-> !host_clk_pin_oe)
        else $error("clock pin not held low");
    a_data_role: assert property (!i2c_mode |=> host_data_pin_oe)
        else $error("data pin driven in spi mode");
    a_data_drive: assert property (i2c_mode && i2c_data_drive_low ##1 i2c_mode |-> !host_data_pin_oe)
        else $error("data pin not driven low");
    a_out_idle: assert property (s_i2c2 |-> spi_data_out_oe)
        else $error("serial output driven in i2c mode");
    a_tx_copy: assert property (spi_selected ##1 spi_selected |-> !spi_data_out_oe && spi_data_out == $past(spi_read_bit))
        else $error("serial output does not follow read bit");
    a_sel_mode: assert property (spi_selected || spi_rx_valid |-> !i2c_mode)
        else $error("spi activity in i2c mode");
    a_no_select: assert property (s_i2c2 |-> !spi_selected)
        else $error("select pin used as chip select in i2c mode");
    a_addr_hold: assert property (!i2c_mode [*3] |-> $stable(addr_select_bit0))
        else $error("address bit moved in spi mode");
    a_irq_set: assert property (s_change |-> ##2 !irq_n_oe)
        else $error("interrupt not raised two cycles after change");
    a_irq_clear: assert property ($rose(irq_n_oe) |-> $past(status_read, 2))
        else $error("interrupt released without a read");
    a_open_drain: assert property (!irq_n_out && !host_clk_pin_out && !host_data_pin_out)
        else $error("open-drain output drives high");
    a_strap_i2c: assert property (bus_select [*8] |-> i2c_mode)
        else $error("strap high but i2c not selected");
    a_strap_spi: assert property (!bus_select [*8] |-> !i2c_mode)
        else $error("strap low but spi not selected");
endmodule // port_select_monitor
bind serial_host_port_select port_select_monitor mon_u (.*);

// ---- tb/spi_host_model.sv ----
// Host master model: frames bytes MSB first at a 125 ns serial clock.
// Assumes the bench resolves pin wires; clock idles high between frames.
`timescale 1ns/1ps
module spi_host_model (
    output logic sck,
    output logic mosi,
    output logic cs_n
);
    // Lines idle released
    initial begin
        sck = 1'b1;
        mosi = 1'b1;
        cs_n = 1'b1;
    end
    // Select pin level outside frames
    task automatic hold_sel(input logic v);
        cs_n = v;
    endtask
    // One byte; chip select low only when frame is set
    task automatic send(input logic [7:0] b, input logic frame);
        integer i;
        cs_n = !frame;
        #100;
        for (i = 7; i >= 0; i--) begin
            sck = 1'b0;
            mosi = b[i];
            #62.5;
            sck = 1'b1;
            #62.5;
        end
        mosi = !b[0];
        #100;
        cs_n = 1'b1;
    endtask
endmodule // spi_host_model

// ---- tb/test_serial_host_port_select.sv ----
// Self-checking bench for the port select block in both modes.
// Assumes the host model drives the pins; pull-ups resolved here.
`timescale 1ns/1ps
module test_serial_host_port_select;
    import port_select_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, bus_select = 1'b1, spi_read_bit = 1'b0;
    logic hold_clk = 1'b0, hold_data = 1'b0, status_read = 1'b0, ce = 1'b1;
    logic [7:0] status_in = 8'h00, status_enable = 8'h00;
    logic sck, mosi, cs_n, clk_oe, clk_o, dat_oe, dat_o, so, so_oe, irq_o, irq_oe;
    logic i2c_mode, spi_selected, addr_bit, clk_lvl, dat_lvl, rx_valid;
    logic [7:0] rx_byte;
    wire clk_w = sck & (clk_oe | clk_o);
    wire dat_w = mosi & (dat_oe | dat_o);
    wire irq_w = irq_oe ? 1'b1 : irq_o;
    int n_mismatch = 0, comparisons = 0;
    always #2 sys_clk = !sys_clk;
    spi_host_model host_u (.sck(sck), .mosi(mosi), .cs_n(cs_n));
    serial_host_port_select dut_u (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .link_clk(sck), .bus_select(bus_select),
        .host_clk_pin_in(clk_w), .host_clk_pin_out(clk_o), .host_clk_pin_oe(clk_oe),
        .host_data_pin_in(dat_w), .host_data_pin_out(dat_o), .host_data_pin_oe(dat_oe),
        .select_or_addr_pin(cs_n), .spi_data_out(so), .spi_data_out_oe(so_oe),
        .irq_n_out(irq_o), .irq_n_oe(irq_oe), .spi_read_bit(spi_read_bit),
        .i2c_clk_hold_low(hold_clk), .i2c_data_drive_low(hold_data),
        .status_in(status_in), .status_enable(status_enable), .status_read(status_read),
        .i2c_mode(i2c_mode), .spi_selected(spi_selected), .addr_select_bit0(addr_bit),
        .i2c_clk_level(clk_lvl), .i2c_data_level(dat_lvl), .spi_rx_byte(rx_byte),
        .spi_rx_valid(rx_valid)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    // Strap stays fixed from reset on
    task automatic do_reset(input logic sel);
        @(posedge sys_clk);
        bus_select <= sel;
        rst <= 1'b1;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        tick(12);
    endtask
    // Sends one byte and counts valid pulses meanwhile
    task automatic spi_byte(input logic [7:0] b, input logic frame, output int c);
        c = 0;
        fork
            host_u.send(b, frame);
            repeat (500) begin
                @(posedge sys_clk);
                #1;
                if (rx_valid === 1'b1) c++;
            end
        join
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_i2c;
        do_reset(1'b1);
        host_u.hold_sel(1'b1);
        tick(12);
        chk(i2c_mode, 8'h01);
        chk(addr_bit, 8'h01);
        host_u.hold_sel(1'b0);
        @(posedge sys_clk);
        hold_clk <= 1'b1;
        hold_data <= 1'b1;
        tick(12);
        chk(addr_bit, 8'h00);
        chk(spi_selected, 8'h00);
        chk({clk_oe, clk_lvl}, 8'h00);
        chk({dat_oe, dat_lvl}, 8'h00);
        chk(so_oe, 8'h01);
        @(posedge sys_clk);
        hold_clk <= 1'b0;
        hold_data <= 1'b0;
        tick(12);
        chk({clk_lvl, dat_lvl}, 8'h03);
    endtask
    task automatic t_spi;
        int c;
        do_reset(1'b0);
        chk(i2c_mode, 8'h00);
        host_u.hold_sel(1'b0);
        @(posedge sys_clk);
        hold_clk <= 1'b1;
        hold_data <= 1'b1;
        spi_read_bit <= 1'b1;
        tick(12);
        chk({so, so_oe, spi_selected}, 8'h05);
        chk({clk_oe, dat_oe}, 8'h03);
        spi_byte(8'ha5, 1'b1, c);
        chk(8'(c), 8'h01);
        chk(rx_byte, 8'ha5);
        spi_byte(8'h3c, 1'b0, c);
        chk(8'(c), 8'h00);
        chk({so_oe, spi_selected}, 8'h02);
    endtask
    // Runs in spi mode to show the line ignores the strap
    task automatic t_irq;
        @(posedge sys_clk);
        status_enable <= 8'h0f;
        status_in <= 8'h10;
        tick(4);
        chk(irq_w, 8'h01);
        @(posedge sys_clk);
        status_in <= 8'h11;
        tick(3);
        chk({irq_oe, irq_w}, 8'h00);
        @(posedge sys_clk);
        status_read <= 1'b1;
        @(posedge sys_clk);
        status_read <= 1'b0;
        tick(3);
        chk(irq_w, 8'h01);
        // Clock enable low holds the interrupt state
        @(posedge sys_clk);
        ce <= 1'b0;
        status_in <= 8'h13;
        tick(4);
        chk(irq_w, 8'h01);
        @(posedge sys_clk);
        ce <= 1'b1;
        tick(3);
        chk(irq_w, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        t_i2c();
        t_spi();
        t_irq();
        end_sim();
    end
    // Watchdog well past the expected run
    initial begin
        #50000;
        n_mismatch++;
        end_sim();
    end
endmodule // test_serial_host_port_select
